/* hw/pw_map.svh */
// Register offsets, field positions, field encodings, response codes and timing constants of the power/wake controller
`ifndef PW_MAP_SVH
`define PW_MAP_SVH

`define PW_OFF_CTRL 8'h00
`define PW_OFF_WAKE 8'h04
`define PW_OFF_ISTS 8'h08
`define PW_OFF_IEN 8'h0C
`define PW_OFF_PHY 8'h10

`define PW_B_READY 0
`define PW_B_PIN_EN 1
`define PW_B_PIN_IND 2
`define PW_B_WSTS 4
`define PW_B_LAN_EN 9
`define PW_B_MODE 12
`define PW_B_ENERGY_DETECT_WAKE_ENABLE 14
`define PW_B_INT_WAKE 0
`define PW_B_PHY_GPD 0
`define PW_B_PHY_EDPD 1

`define PW_MODE_NORMAL 2'h0
`define PW_MODE_LAN 2'h1
`define PW_MODE_ED 2'h2
`define PW_WS_LAN 2'h2
`define PW_WS_ED 2'h1
`define PW_WAKE_RD_VAL 32'h00000000

`define PW_RESP_OKAY 2'h0
`define PW_RESP_SLVERR 2'h2

`define PW_CLOCK_KHZ 40000
`define PW_PULSE_MS 50
`define PW_READY_MS 2
`define PW_CNT_W 22

`endif

/* hw/pw_pkg.sv */
// Types of the power/wake controller
package pw_pkg;

    typedef enum logic [2:0] {
        PW_ST_NORMAL = 3'h1,
        PW_ST_LAN = 3'h2,
        PW_ST_ED = 3'h4
    } pw_state_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } pw_sync_s_t;

    typedef struct packed {
        pw_state_t st;
        logic ready;
        logic rd_seen;
        logic [21:0] rdy_cnt;
        logic [21:0] pulse_cnt;
        logic [1:0] mode;
        logic [1:0] wsts;
        logic lan_en;
        logic energy_detect_wake_enable;
        logic pin_en;
        logic pin_ind;
        logic interrupt_status_register;
        logic int_en;
        logic phy_gpd;
        logic phy_edpd;
        logic phy_rst;
        logic wake_pin;
        logic irq;
        logic mac_clk_en;
        logic host_clk_en;
        logic mac_pm_clk_en;
        logic int_clk_en;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pw_ctrl_s_t;

endpackage

/* hw/pw_sync.sv */
// Two-flop synchroniser for the wake detector inputs
`timescale 1ns/10ps
`default_nettype none
module pw_sync
    import pw_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_en,
    input wire logic [1:0] d,
    output logic [1:0] q
);
    pw_sync_s_t s_reg;
    pw_sync_s_t s_next;

    always_comb begin
        s_next.s1 = d;
        s_next.s2 = s_reg.s1;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else if (clock_en) begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.s2;
endmodule
`default_nettype wire

/* hw/pw_ctrl.sv */
// Power-state and wake-event controller with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pw_map.svh"
module pw_ctrl
    import pw_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = `PW_PULSE_MS * `PW_CLOCK_KHZ,
    parameter int unsigned READY_CYCLES = `PW_READY_MS * `PW_CLOCK_KHZ
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_en,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic wake_frame_det,
    input wire logic carrier_det,
    output logic wake_event_pin,
    output logic host_irq,
    output logic mac_clk_en,
    output logic host_clk_en,
    output logic mac_pm_clk_en,
    output logic internal_clk_en,
    output logic phy_powerdown,
    output logic phy_energy_detect_powerdown,
    output logic phy_reset
);
    localparam logic [21:0] PULSE_LD = `PW_CNT_W'(PULSE_CYCLES);
    localparam logic [21:0] READY_LD = `PW_CNT_W'(READY_CYCLES);
    localparam pw_ctrl_s_t PW_RST = '{st: PW_ST_NORMAL, rdy_cnt: READY_LD, default: '0};

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] pw_word(input logic [7:0] a);
        return {a[7:2], 2'b00};
    endfunction

    function automatic logic pw_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = pw_word(a);
        return (w == `PW_OFF_CTRL) || (w == `PW_OFF_WAKE) || (w == `PW_OFF_ISTS) ||
               (w == `PW_OFF_IEN) || (w == `PW_OFF_PHY);
    endfunction

    function automatic logic pw_wake_sig(input logic [1:0] ws, input logic le, input logic ee);
        return (ws[1] & le) | (ws[0] & ee);
    endfunction

    pw_ctrl_s_t s_reg;
    pw_ctrl_s_t s_next;
    logic [1:0] det_s;
    logic [31:0] wmask;
    logic [7:0] wa;
    logic [7:0] ra;
    logic is_sleep;
    logic wr_do;
    logic wr_wake;
    logic wr_ok;
    logic ar_do;
    logic rd_ok;
    logic ev_lan;
    logic ev_ed;
    logic wake_sig;

    // ----------------------------------------------------------------
    // Detector inputs, write mask and decode
    // ----------------------------------------------------------------
    pw_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clock_en(clock_en),
        .d({carrier_det, wake_frame_det}),
        .q(det_s)
    );

    generate
        for (genvar b = 0; b < 4; b++) begin : g_mask
            assign wmask[8*b +: 8] = {8{s_reg.wstrb[b]}};
        end
    endgenerate

    assign wa = pw_word(s_reg.awaddr);
    assign ra = pw_word(s_axi_araddr);
    assign is_sleep = s_reg.st != PW_ST_NORMAL;
    assign wr_do = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    assign wr_wake = wr_do && is_sleep && (wa == `PW_OFF_WAKE);
    assign wr_ok = wr_do && !is_sleep && s_reg.ready && s_reg.rd_seen;
    assign ar_do = s_reg.arready && s_axi_arvalid;
    // only control readable while not ready
    assign rd_ok = (ra == `PW_OFF_CTRL) || (!is_sleep && s_reg.ready);
    assign ev_lan = (s_reg.st == PW_ST_LAN) && det_s[0] && !s_reg.wsts[1];
    assign ev_ed = (s_reg.st == PW_ST_ED) && det_s[1] && !s_reg.wsts[0];
    assign wake_sig = pw_wake_sig(s_reg.wsts, s_reg.lan_en, s_reg.energy_detect_wake_enable);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.phy_rst = 1'b0;
        if (s_reg.awready && s_axi_awvalid) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_reg.wready && s_axi_wvalid) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (wr_do) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = pw_mapped(s_reg.awaddr) ? `PW_RESP_OKAY : `PW_RESP_SLVERR;
        end
        if (s_reg.st == PW_ST_NORMAL && !s_reg.ready) begin
            if (s_reg.rdy_cnt == '0) begin
                s_next.ready = 1'b1;
            end else begin
                s_next.rdy_cnt = s_reg.rdy_cnt - 22'h000001;
            end
        end
        if (wr_ok) begin
            case (wa)
                `PW_OFF_CTRL: begin
                    if (wmask[`PW_B_PIN_EN]) s_next.pin_en = s_reg.wdata[`PW_B_PIN_EN];
                    if (wmask[`PW_B_PIN_IND]) s_next.pin_ind = s_reg.wdata[`PW_B_PIN_IND];
                    if (wmask[`PW_B_LAN_EN]) s_next.lan_en = s_reg.wdata[`PW_B_LAN_EN];
                    if (wmask[`PW_B_ENERGY_DETECT_WAKE_ENABLE]) s_next.energy_detect_wake_enable = s_reg.wdata[`PW_B_ENERGY_DETECT_WAKE_ENABLE];
                    s_next.wsts = s_reg.wsts & ~(s_reg.wdata[`PW_B_WSTS +: 2] & wmask[`PW_B_WSTS +: 2]);
                    if (wmask[`PW_B_MODE] && s_reg.wdata[`PW_B_MODE +: 2] == `PW_MODE_LAN) begin
                        s_next.st = PW_ST_LAN;
                        s_next.mode = `PW_MODE_LAN;
                        s_next.ready = 1'b0;
                    end
                    if (wmask[`PW_B_MODE] && s_reg.wdata[`PW_B_MODE +: 2] == `PW_MODE_ED) begin
                        s_next.st = PW_ST_ED;
                        s_next.mode = `PW_MODE_ED;
                        s_next.ready = 1'b0;
                    end
                end
                `PW_OFF_ISTS: begin
                    if (wmask[`PW_B_INT_WAKE] && s_reg.wdata[`PW_B_INT_WAKE] && !wake_sig) begin
                        s_next.interrupt_status_register = 1'b0;
                    end
                end
                `PW_OFF_IEN: begin
                    if (wmask[`PW_B_INT_WAKE]) s_next.int_en = s_reg.wdata[`PW_B_INT_WAKE];
                end
                `PW_OFF_PHY: begin
                    if (wmask[`PW_B_PHY_GPD]) begin
                        s_next.phy_gpd = s_reg.wdata[`PW_B_PHY_GPD];
                        s_next.phy_rst = s_reg.phy_gpd && !s_reg.wdata[`PW_B_PHY_GPD];
                    end
                    if (wmask[`PW_B_PHY_EDPD]) s_next.phy_edpd = s_reg.wdata[`PW_B_PHY_EDPD];
                end
                default: begin
                end
            endcase
        end
        if (ev_lan) s_next.wsts[1] = 1'b1;
        if (ev_ed) s_next.wsts[0] = 1'b1;
        if (ev_lan || ev_ed) s_next.interrupt_status_register = 1'b1;
        if (ev_lan || ev_ed) begin
            s_next.pulse_cnt = PULSE_LD;
        end else if (s_reg.pulse_cnt != '0) begin
            s_next.pulse_cnt = s_reg.pulse_cnt - 22'h000001;
        end
        if (ar_do) begin
            s_next.rvalid = 1'b1;
            s_next.rd_seen = 1'b1;
            s_next.rresp = (pw_mapped(s_axi_araddr) && rd_ok) ? `PW_RESP_OKAY : `PW_RESP_SLVERR;
            s_next.rdata = '0;
            if (rd_ok) begin
                case (ra)
                    `PW_OFF_CTRL: begin
                        s_next.rdata[`PW_B_READY] = s_reg.ready;
                        s_next.rdata[`PW_B_PIN_EN] = s_reg.pin_en;
                        s_next.rdata[`PW_B_PIN_IND] = s_reg.pin_ind;
                        s_next.rdata[`PW_B_WSTS +: 2] = s_reg.wsts;
                        s_next.rdata[`PW_B_LAN_EN] = s_reg.lan_en;
                        s_next.rdata[`PW_B_MODE +: 2] = s_reg.mode;
                        s_next.rdata[`PW_B_ENERGY_DETECT_WAKE_ENABLE] = s_reg.energy_detect_wake_enable;
                    end
                    `PW_OFF_WAKE: s_next.rdata = `PW_WAKE_RD_VAL;
                    `PW_OFF_ISTS: s_next.rdata[`PW_B_INT_WAKE] = s_reg.interrupt_status_register;
                    `PW_OFF_IEN: s_next.rdata[`PW_B_INT_WAKE] = s_reg.int_en;
                    `PW_OFF_PHY: begin
                        s_next.rdata[`PW_B_PHY_GPD] = s_reg.phy_gpd;
                        s_next.rdata[`PW_B_PHY_EDPD] = s_reg.phy_edpd;
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (wr_wake) begin
            s_next.st = PW_ST_NORMAL;
            s_next.mode = `PW_MODE_NORMAL;
            s_next.ready = 1'b0;
            s_next.rdy_cnt = READY_LD;
            s_next.rd_seen = 1'b0;
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
        s_next.mac_clk_en = s_next.st == PW_ST_NORMAL;
        s_next.host_clk_en = s_next.st == PW_ST_NORMAL;
        s_next.mac_pm_clk_en = s_next.st != PW_ST_ED;
        s_next.int_clk_en = s_next.st != PW_ST_ED;
        s_next.wake_pin = s_next.pin_en && pw_wake_sig(s_next.wsts, s_next.lan_en, s_next.energy_detect_wake_enable) &&
                          (!s_next.pin_ind || s_next.pulse_cnt != '0);
        s_next.irq = s_next.interrupt_status_register && s_next.int_en;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_reg <= PW_RST;
        end else if (clock_en) begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign wake_event_pin = s_reg.wake_pin;
    assign host_irq = s_reg.irq;
    assign mac_clk_en = s_reg.mac_clk_en;
    assign host_clk_en = s_reg.host_clk_en;
    assign mac_pm_clk_en = s_reg.mac_pm_clk_en;
    assign internal_clk_en = s_reg.int_clk_en;
    assign phy_powerdown = s_reg.phy_gpd;
    assign phy_energy_detect_powerdown = s_reg.phy_edpd;
    assign phy_reset = s_reg.phy_rst;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n || !clock_en);

    property p_sleep_not_ready;
        (s_reg.st != PW_ST_NORMAL) |-> !s_reg.ready && s_reg.mode != `PW_MODE_NORMAL;
    endproperty
    a_sleep_not_ready: assert property (p_sleep_not_ready) else $error("ready set in sleep");

    property p_lan_entry;
        (wr_ok && wa == `PW_OFF_CTRL && s_reg.wstrb[1] && s_reg.wdata[13:12] == `PW_MODE_LAN && !wr_wake)
            |=> s_reg.st == PW_ST_LAN && s_reg.mode == `PW_MODE_LAN && !s_reg.ready;
    endproperty
    a_lan_entry: assert property (p_lan_entry) else $error("mode 01 did not enter LAN sleep");

    property p_wake_return;
        wr_wake |=> s_reg.st == PW_ST_NORMAL && s_reg.mode == `PW_MODE_NORMAL && !s_reg.rd_seen;
    endproperty
    a_wake_return: assert property (p_wake_return) else $error("wake write did not return");

    property p_ready_time;
        (s_reg.st == PW_ST_NORMAL && !s_reg.ready && s_reg.rdy_cnt == '0) |=> s_reg.ready;
    endproperty
    a_ready_time: assert property (p_ready_time) else $error("ready late after countdown");

    property p_lan_clocks;
        (s_reg.st == PW_ST_LAN) |=> (s_reg.st != PW_ST_LAN) ||
            (!s_reg.mac_clk_en && !s_reg.host_clk_en && s_reg.int_clk_en && s_reg.mac_pm_clk_en);
    endproperty
    a_lan_clocks: assert property (p_lan_clocks) else $error("wrong clocks in LAN sleep");

    property p_ed_clocks;
        $rose(s_reg.st == PW_ST_ED) |-> !s_reg.int_clk_en && !s_reg.mac_pm_clk_en && !s_reg.mac_clk_en;
    endproperty
    a_ed_clocks: assert property (p_ed_clocks) else $error("clocks run in energy-detect sleep");

    property p_ev_status;
        (ev_lan || ev_ed) |=> s_reg.interrupt_status_register ##1 (s_reg.irq == s_reg.int_en || !s_reg.interrupt_status_register);
    endproperty
    a_ev_status: assert property (p_ev_status) else $error("wake event lost");

    property p_int_hold;
        (s_reg.interrupt_status_register && wake_sig) |=> s_reg.interrupt_status_register;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("status cleared while wake signal set");

    property p_pin_off;
        (!s_reg.pin_en || !wake_sig) |-> !s_reg.wake_pin;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin active without cause");

    property p_lan_status;
        ev_lan |=> s_reg.wsts[1] && (s_reg.wake_pin == (s_reg.lan_en && s_reg.pin_en));
    endproperty
    a_lan_status: assert property (p_lan_status) else $error("LAN detection not flagged");

    property p_write_gate;
        (wr_do && !wr_ok && !wr_wake) |=> $stable(s_reg.int_en) && $stable(s_reg.pin_en);
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("refused write changed state");

    c_lan_wake: cover property (ev_lan ##[1:20] wr_wake);
    c_ed_wake: cover property (ev_ed ##1 s_reg.wake_pin);
    c_ready: cover property (wr_wake ##[1:1000] s_reg.ready);
endmodule
`default_nettype wire

/* verif/pw_line_model.sv */
// Line-side model: wake frame detector and carrier levels
`timescale 1ns/10ps
`default_nettype none
module pw_line_model (
    input wire logic clock,
    input wire logic frame_req,
    input wire logic carrier_req,
    output logic wake_frame_det,
    output logic carrier_det
);
    // Detector levels change just after an edge, unrelated to the bus
    always_ff @(posedge clock) begin
        wake_frame_det <= frame_req;
        carrier_det <= carrier_req;
    end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench of the power/wake controller
`timescale 1ns/10ps
`default_nettype none
`include "pw_map.svh"
module tb_top;
    localparam int PC = 20;
    localparam int RC = 10;
    logic clock, rst_n, clock_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic wake_frame_det, carrier_det, frame_req, carrier_req, wake_event_pin, host_irq;
    logic mac_clk_en, host_clk_en, mac_pm_clk_en, internal_clk_en;
    logic phy_powerdown, phy_energy_detect_powerdown, phy_reset;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int bad_count, n_compared, seed, cnt, rst_seen;

    pw_ctrl #(.PULSE_CYCLES(PC), .READY_CYCLES(RC)) i_pw_ctrl (.*);
    pw_line_model i_pw_line_model (.*);

    always #12.5 clock = ~clock;
    always @(posedge clock) if (phy_reset === 1'b1) rst_seen++;

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awprot <= 3'($random(seed));
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            s_axi_awvalid <= s_axi_awvalid && s_axi_awready !== 1'b1;
            s_axi_wvalid <= s_axi_wvalid && s_axi_wready !== 1'b1;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arprot <= 3'($random(seed));
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            s_axi_arvalid <= s_axi_arvalid && s_axi_arready !== 1'b1;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // Wake with random data, then poll only the control register
    task automatic wake_up();
        wr(`PW_OFF_WAKE, $random(seed));
        do rd(`PW_OFF_CTRL); while (d[0] !== 1'b1);
    endtask

    function automatic logic [31:0] exp_ws(input logic lan);
        return lan ? 32'(`PW_WS_LAN) : 32'(`PW_WS_ED);
    endfunction

    task automatic clks(input logic [3:0] e);
        chk("clock_enables", 32'({mac_clk_en, host_clk_en, mac_pm_clk_en, internal_clk_en}), 32'(e));
    endtask

    task automatic stop_test();
        $display("Compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hCA33;
        clock = 1'b0;
        rst_n = 1'b0;
        clock_en = 1'b1;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, frame_req, carrier_req} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (RC + 5) @(posedge clock);
        wr(`PW_OFF_IEN, 32'h1);
        rd(`PW_OFF_IEN);
        chk("ien_before_read", d, 32'h0);
        wr(`PW_OFF_IEN, 32'h1);
        chk("wr_resp", 32'(r), 32'(`PW_RESP_OKAY));
        rd(`PW_OFF_IEN);
        chk("ien", d, 32'h1);
        rd(8'h14 + 8'(4 * ($unsigned($random(seed)) % 59)));
        chk("unmapped_resp", 32'(r), 32'(`PW_RESP_SLVERR));
        // pin and lan enables in the same write as LAN entry
        wr(`PW_OFF_CTRL, 32'h1202);
        repeat (3) @(posedge clock);
        clks(4'b0011);
        rd(`PW_OFF_CTRL);
        chk("ready_lan", 32'(d[0]), 32'h0);
        rd(`PW_OFF_IEN);
        chk("sleep_read_resp", 32'(r), 32'(`PW_RESP_SLVERR));
        frame_req <= 1'b1;
        repeat (8) @(posedge clock);
        chk("pin_lan", 32'(wake_event_pin), 32'h1);
        chk("irq_lan", 32'(host_irq), 32'h1);
        rd(`PW_OFF_CTRL);
        chk("wsts_lan", 32'(d[5:4]), exp_ws(1'b1));
        repeat (PC + 10) @(posedge clock);
        chk("pin_level", 32'(wake_event_pin), 32'h1);
        frame_req <= 1'b0;
        wake_up();
        clks(4'b1111);
        rd(`PW_OFF_CTRL);
        chk("mode_normal", 32'(d[13:12]), 32'(`PW_MODE_NORMAL));
        chk("kept_cfg", 32'({d[9], d[1]}), 32'h3);
        wr(`PW_OFF_ISTS, 32'h1);
        rd(`PW_OFF_ISTS);
        chk("ists_held", d, 32'h1);
        wr(`PW_OFF_CTRL, 32'h0232);
        chk("pin_cleared", 32'(wake_event_pin), 32'h0);
        chk("irq_kept", 32'(host_irq), 32'h1);
        wr(`PW_OFF_ISTS, 32'h1);
        chk("irq_cleared", 32'(host_irq), 32'h0);
        carrier_req <= 1'b1;
        wr(`PW_OFF_PHY, 32'h2);
        chk("edpd_set", 32'(phy_energy_detect_powerdown), 32'h1);
        wr(`PW_OFF_CTRL, 32'h6006);
        cnt = 0;
        repeat (PC + 20) @(posedge clock) cnt += int'(wake_event_pin === 1'b1);
        chk("pulse_len", 32'(cnt), 32'(PC));
        chk("pin_after_pulse", 32'(wake_event_pin), 32'h0);
        clks(4'b0000);
        chk("irq_ed", 32'(host_irq), 32'h1);
        rd(`PW_OFF_CTRL);
        chk("wsts_ed", 32'(d[5:4]), exp_ws(1'b0));
        carrier_req <= 1'b0;
        wake_up();
        wr(`PW_OFF_PHY, 32'h0);
        chk("edpd_clear", 32'(phy_energy_detect_powerdown), 32'h0);
        wr(`PW_OFF_PHY, 32'h1);
        chk("gpd_set", 32'(phy_powerdown), 32'h1);
        wr(`PW_OFF_PHY, 32'h0);
        repeat (2) @(posedge clock);
        chk("phy_reset_pulses", 32'(rst_seen), 32'h1);
        // Second reset: writes must be refused again until a read
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (RC + 5) @(posedge clock);
        wr(`PW_OFF_IEN, 32'h1);
        rd(`PW_OFF_IEN);
        chk("ien_after_reset", d, 32'h0);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
